// File: bench/branch_skip_bit_flag_exec_tb.sv
// Purpose: self-checking bench for the exec unit
// Assumes: one op every two clocks; fetch model owns pc
// Notes: expected status st is tracked here
`timescale 1ns/1ps
module branch_skip_bit_flag_exec_tb
  import bitops_pkg::*;
;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  fails++; $display("wrong value %s exp %h got %h", n, e, g); end end
  logic clk_i = 0, rst_b_i = 0, issue_i = 0, lng = 0, t, c;
  op_t op_i = op_none;
  logic [2:0] bs = 0;
  logic [6:0] k = 0;
  logic [1:0] d;
  logic [7:0] rv = 0, iv = 0, st = 0, r, x;
  logic [15:0] pc_i, p, e, pc_next_o;
  logic pc_load_o, taken_o, reg_we_o, io_we_o;
  logic [1:0] cycles_o;
  logic [7:0] reg_wdata_o, io_wdata_o, status_register_o;
  int fails = 0, num_checks = 0;
  int fo[20] = '{5, 5, 1, 1, 0, 0, 0, 0, 2, 2, 3, 3, 5, 5, 6, 6, 3, 3, 7, 7};
  logic [0:19] pol = 20'b1010_1001_1010_1010_1010;
  op_t so[8] = '{carry_flag_set_op, zero_flag_set_op, negative_flag_set_op,
    overflow_flag_set_op, sign_flag_set_op, status_bit_set_op,
    status_bit_set_op, global_irq_on};
  op_t co[8] = '{carry_flag_clear_op, zero_flag_clear_op,
    negative_flag_clear_op, overflow_flag_clear_op, sign_flag_clear_op,
    status_bit_clear_op, status_bit_clear_op, global_irq_off};
  op_t sh[6] = '{logical_left_shift, logical_right_shift, rotate_left_carry,
    rotate_right_carry, arith_shift_right, nibble_swap};

  branch_skip_bit_flag_exec dut (.clk_i, .rst_b_i, .issue_i, .op_i, .pc_i,
    .bit_sel_i(bs), .offset_i(k), .next_is_long_i(lng), .reg_value_i(rv),
    .io_value_i(iv), .pc_load_o, .pc_next_o, .cycles_o, .taken_o,
    .reg_we_o, .reg_wdata_o, .io_we_o, .io_wdata_o, .status_register_o);
  fetch_model fetch (.clk_i, .rst_b_i, .pc_load_i(pc_load_o),
    .pc_next_i(pc_next_o), .pc_o(pc_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // one issue pulse; results are settled on return
  task automatic go(op_t o, logic [2:0] b, logic [7:0] r0, i0);
    @(negedge clk_i);
    p = pc_i;
    op_i = o;
    bs = b;
    rv = r0;
    iv = i0;
    issue_i = 1;
    @(negedge clk_i);
    issue_i = 0;
  endtask

  task automatic fl(op_t o, int b, logic v);
    go(o, b[2:0], 0, 0);
    st[b] = v;
    `CHK("status", st, status_register_o)
  endtask

  task automatic pcchk(logic tk, logic [15:0] ep, logic [1:0] ec);
    `CHK("taken", tk, taken_o)
    `CHK("next pc", ep, pc_next_o)
    `CHK("cycles", ec, cycles_o)
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk_i);
    rst_b_i = 1;
    for (int i = 0; i < 8; i++) begin
      fl(so[i], i, 1);
      fl(co[i], i, 0);
    end
    $display("flag ops done");
    // extreme offsets in both directions
    for (int i = 0; i < 20; i++) begin
      for (int v = 0; v < 2; v++) begin
        fl(status_bit_set_op, FLAG_N, 1);
        fl(v ? status_bit_set_op : status_bit_clear_op, fo[i], v[0]);
        k = v ? 7'h40 : 7'h3f;
        go(op_t'(int'(branch_on_status_bit_set) + i), 3'h5, 0, 0);
        t = v[0] == pol[i];
        e = t ? {{9{k[6]}}, k} + 16'h1 : 16'h1;
        d = t ? 2'h2 : 2'h1;
        pcchk(t, p + e, d);
        `CHK("status", st, status_register_o)
      end
    end
    $display("branches done");
    for (int i = 0; i < 4; i++) begin
      for (int v = 0; v < 4; v++) begin
        lng = v[1];
        r = v[0] ? 8'h80 : 8'h7f;
        go(op_t'(int'(skip_if_reg_bit_set) + i), 3'h7, i < 2 ? r : ~r,
          i < 2 ? ~r : r);
        t = v[0] == (i == 0 || i == 3);
        e = t ? 16'h2 + lng : 16'h1;
        pcchk(t, p + e, e[1:0]);
      end
    end
    $display("skips done");
    for (int i = 0; i < 2; i++) begin
      go(set_io_bit, i ? 3'h7 : 3'h0, 0, 8'h5a);
      `CHK("io set", i ? 8'hda : 8'h5b, io_wdata_o)
      `CHK("io we", 1'b1, io_we_o)
      go(clear_io_bit, i ? 3'h6 : 3'h1, 0, 8'h5a);
      `CHK("io clear", i ? 8'h1a : 8'h58, io_wdata_o)
      `CHK("io we", 1'b1, io_we_o)
      `CHK("cycles", 2'h2, cycles_o)
      `CHK("status", st, status_register_o)
    end
    $display("io bits done");
    for (int i = 0; i < 6; i++) begin
      for (int v = 0; v < 4; v++) begin
        fl(v[0] ? carry_flag_set_op : carry_flag_clear_op, FLAG_C, v[0]);
        r = v[1] ? 8'h81 : 8'h01;
        go(sh[i], 0, r, 0);
        case (i)
          0: {c, x} = {r, 1'b0};
          1: {x, c} = {1'b0, r};
          2: {c, x} = {r, v[0]};
          3: {x, c} = {v[0], r};
          4: {x, c} = {r[7], r};
          default: x = {r[3:0], r[7:4]};
        endcase
        if (i < 5) st[3:0] = {x[7] ^ c, x[7], x == 8'h00, c};
        `CHK("result", x, reg_wdata_o)
        `CHK("reg we", 1'b1, reg_we_o)
        `CHK("status", st, status_register_o)
      end
    end
    $display("shifts done");
    for (int v = 0; v < 2; v++) begin
      go(store_reg_bit_to_transfer_flag, 3'h3, v ? 8'h08 : 8'hf7, 0);
      st[FLAG_T] = v[0];
      `CHK("status", st, status_register_o)
      go(load_reg_bit_from_transfer_flag, 3'h5, v ? 8'h00 : 8'hff, 0);
      `CHK("bit load", v ? 8'h20 : 8'hdf, reg_wdata_o)
      `CHK("reg we", 1'b1, reg_we_o)
      `CHK("status", st, status_register_o)
    end
    go(op_none, 0, 0, 0);
    pcchk(0, p + 16'h1, 2'h1);
    `CHK("io we", 1'b0, io_we_o)
    $display("transfer bit and idle done");
    // reset in mid-run must drop the flags again
    fl(global_irq_on, FLAG_I, 1);
    rst_b_i = 0;
    @(negedge clk_i);
    `CHK("status", 8'h00, status_register_o)
    rst_b_i = 1;
    st = 0;
    fl(global_irq_on, FLAG_I, 1);
    $display("reset done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end
endmodule

// File: bench/exec_properties.sv
// Purpose: port-level checks for the exec unit
// Assumes: results land one clock after issue_i
// Notes: bound to the design top below
`timescale 1ns/1ps
module exec_properties
  import bitops_pkg::*;
(
  // clock, reset and issue
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic issue_i,
  input wire op_t op_i,
  input wire logic [15:0] pc_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [6:0] offset_i,
  input wire logic next_is_long_i,
  input wire logic [7:0] io_value_i,
  // results
  input wire logic pc_load_o,
  input wire logic [15:0] pc_next_o,
  input wire logic [1:0] cycles_o,
  input wire logic taken_o,
  input wire logic io_we_o,
  input wire logic [7:0] io_wdata_o,
  input wire logic [7:0] status_register_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic br = op_i >= branch_on_status_bit_set &&
    op_i <= branch_irq_off;
  wire logic sk = op_i >= skip_if_reg_bit_set &&
    op_i <= skip_if_io_bit_high;
  wire logic [15:0] tgt = pc_i + {{9{offset_i[6]}}, offset_i} + 16'h1;
  wire logic [7:0] msk = 8'h01 << bit_sel_i;
  wire logic iob = io_value_i[bit_sel_i];
  wire logic cf = status_register_o[FLAG_C];
  wire logic nv = status_register_o[FLAG_N] ^ status_register_o[FLAG_V];

  load_pulse_a: assert property (pc_load_o == $past(issue_i))
    else $error("load pulse misplaced");
  branch_target_a: assert property (issue_i && br |=>
    (taken_o ? pc_next_o == $past(tgt) && cycles_o == 2'h2
      : pc_next_o == $past(pc_i) + 16'h1 && cycles_o == 2'h1))
    else $error("branch pc or cycles wrong");
  skip_length_a: assert property (issue_i && sk |=>
    {14'h0, cycles_o} == pc_next_o - $past(pc_i) &&
    (!taken_o || cycles_o == ($past(next_is_long_i) ? 2'h3 : 2'h2)))
    else $error("skip pc or cycles wrong");
  io_skip_a: assert property (
    issue_i && op_i == skip_if_io_bit_clear |=> taken_o != $past(iob))
    else $error("io clear skip decision wrong");
  io_set_a: assert property (issue_i && op_i == set_io_bit |=>
    io_we_o && io_wdata_o == ($past(io_value_i) | $past(msk))
    && cycles_o == 2'h2) else $error("io bit set wrong");
  flags_kept_a: assert property (issue_i && (br || sk) |=>
    $stable(status_register_o)) else $error("status changed");
  signed_ge_a: assert property (
    issue_i && op_i == branch_signed_ge |=> taken_o != $past(nv))
    else $error("signed ge decision wrong");
  carry_branch_a: assert property (
    issue_i && op_i == branch_unsigned_lower |=> taken_o == $past(cf))
    else $error("lower branch decision wrong");
  irq_on_a: assert property (issue_i && op_i == global_irq_on |=>
    status_register_o == ($past(status_register_o) | 8'h80))
    else $error("irq enable wrong");
endmodule

bind branch_skip_bit_flag_exec exec_properties chk (.clk_i, .rst_b_i,
  .issue_i, .op_i, .pc_i, .bit_sel_i, .offset_i, .next_is_long_i,
  .io_value_i, .pc_load_o, .pc_next_o, .cycles_o, .taken_o, .io_we_o,
  .io_wdata_o, .status_register_o);

// File: bench/fetch_model.sv
// Purpose: fetch side stand-in holding the program counter
// Assumes: pc_load_i pulses one clock after each issue
// Notes: no stalls; fetch only follows the loads
`timescale 1ns/1ps
module fetch_model
  import bitops_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // from the exec unit
  input wire logic pc_load_i,
  input wire logic [15:0] pc_next_i,
  // to the exec unit
  output logic [15:0] pc_o
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_o <= PC_RESET;
    end else if (pc_load_i) begin
      pc_o <= pc_next_i;
    end
  end
endmodule

// File: rtl/bitops_pkg.sv
// Purpose: shared constants for the branch, skip and bit-operation unit
// Assumes: 8-bit data, 16-bit word program counter, 7-bit offsets
// Notes: status register bit order is C Z N V S H T I (bit 0 upward)
package bitops_pkg;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam int OFFSET_MSB = 6;

  typedef enum logic [5:0] {
    op_none,
    skip_if_reg_bit_set,
    skip_if_reg_bit_clear,
    skip_if_io_bit_clear,
    skip_if_io_bit_high,
    branch_on_status_bit_set,
    branch_on_status_bit_clear,
    branch_on_equal,
    branch_not_equal,
    branch_carry_high,
    branch_carry_low,
    branch_same_or_higher,
    branch_unsigned_lower,
    branch_on_negative,
    branch_on_positive,
    branch_signed_ge,
    branch_signed_less,
    branch_half_carry_high,
    branch_half_carry_low,
    branch_transfer_high,
    branch_transfer_low,
    branch_overflow_high,
    branch_overflow_low,
    branch_irq_on,
    branch_irq_off,
    set_io_bit,
    clear_io_bit,
    logical_left_shift,
    logical_right_shift,
    rotate_left_carry,
    rotate_right_carry,
    arith_shift_right,
    nibble_swap,
    status_bit_set_op,
    status_bit_clear_op,
    store_reg_bit_to_transfer_flag,
    load_reg_bit_from_transfer_flag,
    global_irq_on,
    global_irq_off,
    overflow_flag_set_op,
    overflow_flag_clear_op,
    sign_flag_set_op,
    sign_flag_clear_op,
    carry_flag_set_op,
    carry_flag_clear_op,
    negative_flag_set_op,
    negative_flag_clear_op,
    zero_flag_set_op,
    zero_flag_clear_op
  } op_t;
endpackage

// File: rtl/branch_skip_bit_flag_exec.sv
// Purpose: execute stage for skips, flag branches and bit operations
// Assumes: one op per issue pulse; fetch supplies pc, operands and
//   whether the following instruction is two words long
// Notes: results and next pc appear one clock after issue_i
//
// Overview of operation
// - register bit skip, pc +2 or +3
// - io bit clear skip, 1 to 3 cycles
// - io bit set skip, else continue
// - status bit set branch, pc+k+1
// - status bit clear branch, pc+k+1
// - carry branches: set/lower, clear/same-higher
// - signed ge branch when n^v zero
// - signed less branch when n^v one
// - half carry branches, flags untouched
// - transfer flag branches
// - overflow flag branches, 1 or 2 cycles
// - interrupt flag branches, same target
// - io bit set, two cycles, no flags
// - io bit clear, two cycles, no flags
// - rotate left through carry, flags updated
// - rotate right through carry, flags updated
// - arithmetic shift right keeps sign
// - register bit copied to transfer flag
// - transfer flag copied to register bit
// - interrupt enable set and clear
// - overflow flag set and clear
// - sign, carry, negative, zero set/clear
`timescale 1ns/1ps
module branch_skip_bit_flag_exec
  import bitops_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // issue from fetch
  input wire logic issue_i,
  input wire op_t op_i,
  input wire logic [15:0] pc_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [6:0] offset_i,
  input wire logic next_is_long_i,
  // operands
  input wire logic [7:0] reg_value_i,
  input wire logic [7:0] io_value_i,
  // program counter update
  output logic pc_load_o,
  output logic [15:0] pc_next_o,
  output logic [1:0] cycles_o,
  output logic taken_o,
  // register write back
  output logic reg_we_o,
  output logic [7:0] reg_wdata_o,
  // io write back
  output logic io_we_o,
  output logic [7:0] io_wdata_o,
  // status register
  output logic [7:0] status_register_o
);
  logic [7:0] status_register;
  logic [7:0] bit_mask;
  logic sel_reg_bit;
  logic sel_io_bit;
  logic sel_status_bit;
  logic signed_lt;
  logic skip_cond;
  logic is_skip;
  logic branch_cond;
  logic is_branch;
  logic is_shift;
  logic [15:0] branch_target;
  logic [15:0] skip_target;
  logic [7:0] shift_result;
  logic shift_c;
  logic shift_z;
  logic shift_n;
  logic shift_v;
  logic [7:0] next_status;
  logic [15:0] next_pc;
  logic [1:0] next_cycles;
  logic next_taken;
  logic next_reg_we;
  logic [7:0] next_reg_wdata;
  logic next_io_we;
  logic [7:0] next_io_wdata;

  assign bit_mask = 8'h01 << bit_sel_i;
  assign sel_reg_bit = reg_value_i[bit_sel_i];
  assign sel_io_bit = io_value_i[bit_sel_i];
  assign sel_status_bit = status_register[bit_sel_i];
  assign signed_lt = status_register[FLAG_N] ^ status_register[FLAG_V];
  // sign-extended offset; wraps within the 16-bit word space
  assign branch_target = pc_i + {{(15 - OFFSET_MSB){offset_i[OFFSET_MSB]}},
    offset_i} + PC_STEP_ONE;
  assign skip_target = pc_i + (next_is_long_i ? PC_STEP_THREE : PC_STEP_TWO);

  shift_unit u_shift (
    .op_i(op_i),
    .operand_i(reg_value_i),
    .carry_i(status_register[FLAG_C]),
    .result_o(shift_result),
    .carry_o(shift_c),
    .zero_o(shift_z),
    .neg_o(shift_n),
    .ovf_o(shift_v)
  );

  // skip conditions
  always_comb begin
    is_skip = 1'b1;
    case (op_i)
      skip_if_reg_bit_set: skip_cond = sel_reg_bit;
      skip_if_reg_bit_clear: skip_cond = ~sel_reg_bit;
      skip_if_io_bit_clear: skip_cond = ~sel_io_bit;
      skip_if_io_bit_high: skip_cond = sel_io_bit;
      default: begin
        skip_cond = 1'b0;
        is_skip = 1'b0;
      end
    endcase
  end

  // branch conditions
  always_comb begin
    is_branch = 1'b1;
    case (op_i)
      branch_on_status_bit_set: branch_cond = sel_status_bit;
      branch_on_status_bit_clear: branch_cond = ~sel_status_bit;
      branch_on_equal: branch_cond = status_register[FLAG_Z];
      branch_not_equal: branch_cond = ~status_register[FLAG_Z];
      branch_on_negative: branch_cond = status_register[FLAG_N];
      branch_on_positive: branch_cond = ~status_register[FLAG_N];
      branch_carry_high: branch_cond = status_register[FLAG_C];
      branch_unsigned_lower: branch_cond = status_register[FLAG_C];
      branch_carry_low: branch_cond = ~status_register[FLAG_C];
      branch_same_or_higher: branch_cond = ~status_register[FLAG_C];
      branch_signed_ge: branch_cond = ~signed_lt;
      branch_signed_less: branch_cond = signed_lt;
      branch_half_carry_high: branch_cond = status_register[FLAG_H];
      branch_half_carry_low: branch_cond = ~status_register[FLAG_H];
      branch_transfer_high: branch_cond = status_register[FLAG_T];
      branch_transfer_low: branch_cond = ~status_register[FLAG_T];
      branch_overflow_high: branch_cond = status_register[FLAG_V];
      branch_overflow_low: branch_cond = ~status_register[FLAG_V];
      branch_irq_on: branch_cond = status_register[FLAG_I];
      branch_irq_off: branch_cond = ~status_register[FLAG_I];
      default: begin
        branch_cond = 1'b0;
        is_branch = 1'b0;
      end
    endcase
  end

  assign is_shift = (op_i == logical_left_shift) ||
    (op_i == logical_right_shift) || (op_i == rotate_left_carry) ||
    (op_i == rotate_right_carry) || (op_i == arith_shift_right);

  // pc and cycle count
  always_comb begin
    next_pc = pc_i + PC_STEP_ONE;
    next_cycles = CYC_ONE;
    next_taken = 1'b0;
    if (is_skip && skip_cond) begin
      // two words skipped costs three cycles
      next_pc = skip_target;
      next_cycles = next_is_long_i ? CYC_THREE : CYC_TWO;
      next_taken = 1'b1;
    end else if (is_branch && branch_cond) begin
      next_pc = branch_target;
      next_cycles = CYC_TWO;
      next_taken = 1'b1;
    end else if (op_i == set_io_bit || op_i == clear_io_bit) begin
      next_cycles = CYC_TWO;
    end
  end

  // status, register and io write back
  always_comb begin
    next_status = status_register;
    next_reg_we = 1'b0;
    next_reg_wdata = reg_value_i;
    next_io_we = 1'b0;
    next_io_wdata = io_value_i;
    case (op_i)
      set_io_bit: begin
        next_io_we = 1'b1;
        next_io_wdata = io_value_i | bit_mask;
      end
      clear_io_bit: begin
        next_io_we = 1'b1;
        next_io_wdata = io_value_i & ~bit_mask;
      end
      nibble_swap: begin
        next_reg_we = 1'b1;
        next_reg_wdata = shift_result;
      end
      status_bit_set_op: next_status = status_register | bit_mask;
      status_bit_clear_op: next_status = status_register & ~bit_mask;
      store_reg_bit_to_transfer_flag: next_status[FLAG_T] = sel_reg_bit;
      load_reg_bit_from_transfer_flag: begin
        next_reg_we = 1'b1;
        next_reg_wdata = status_register[FLAG_T] ? (reg_value_i | bit_mask)
          : (reg_value_i & ~bit_mask);
      end
      global_irq_on: next_status[FLAG_I] = 1'b1;
      global_irq_off: next_status[FLAG_I] = 1'b0;
      overflow_flag_set_op: next_status[FLAG_V] = 1'b1;
      overflow_flag_clear_op: next_status[FLAG_V] = 1'b0;
      sign_flag_set_op: next_status[FLAG_S] = 1'b1;
      sign_flag_clear_op: next_status[FLAG_S] = 1'b0;
      carry_flag_set_op: next_status[FLAG_C] = 1'b1;
      carry_flag_clear_op: next_status[FLAG_C] = 1'b0;
      negative_flag_set_op: next_status[FLAG_N] = 1'b1;
      negative_flag_clear_op: next_status[FLAG_N] = 1'b0;
      zero_flag_set_op: next_status[FLAG_Z] = 1'b1;
      zero_flag_clear_op: next_status[FLAG_Z] = 1'b0;
      default: begin
        // shifts update z c n v only
        if (is_shift) begin
          next_reg_we = 1'b1;
          next_reg_wdata = shift_result;
          next_status[FLAG_C] = shift_c;
          next_status[FLAG_Z] = shift_z;
          next_status[FLAG_N] = shift_n;
          next_status[FLAG_V] = shift_v;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_register <= STATUS_RESET;
    end else if (issue_i) begin
      status_register <= next_status;
    end
  end

  // outputs registered; strobes last one clock
  // fetch waits on this pulse, so it must never stretch
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_load_o <= 1'b0;
    end else begin
      pc_load_o <= issue_i;
    end
  end

  // write strobes gated by issue, never by data alone
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_we_o <= 1'b0;
    end else begin
      reg_we_o <= issue_i & next_reg_we;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      io_we_o <= 1'b0;
    end else begin
      io_we_o <= issue_i & next_io_we;
    end
  end

  // mirrors the internal copy, same edge, no lag
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_register_o <= STATUS_RESET;
    end else begin
      status_register_o <= issue_i ? next_status : status_register;
    end
  end

  // data outputs hold until the next issue
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_next_o <= PC_RESET;
    end else if (issue_i) begin
      pc_next_o <= next_pc;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cycles_o <= CYC_ONE;
    end else if (issue_i) begin
      cycles_o <= next_cycles;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      taken_o <= 1'b0;
    end else if (issue_i) begin
      taken_o <= next_taken;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_wdata_o <= 8'h00;
    end else if (issue_i) begin
      reg_wdata_o <= next_reg_wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      io_wdata_o <= 8'h00;
    end else if (issue_i) begin
      io_wdata_o <= next_io_wdata;
    end
  end
endmodule

// File: rtl/shift_unit.sv
// Purpose: single-cycle shift, rotate and nibble-swap datapath
// Assumes: combinational, driven from the execute stage
// Notes: flags follow the usual shift convention, v = n xor c
`timescale 1ns/1ps
module shift_unit
  import bitops_pkg::*;
(
  // operation and operands
  input wire op_t op_i,
  input wire logic [7:0] operand_i,
  input wire logic carry_i,
  // results
  output logic [7:0] result_o,
  output logic carry_o,
  output logic zero_o,
  output logic neg_o,
  output logic ovf_o
);
  always_comb begin
    result_o = operand_i;
    carry_o = carry_i;
    case (op_i)
      logical_left_shift: begin
        result_o = {operand_i[6:0], 1'b0};
        carry_o = operand_i[7];
      end
      logical_right_shift: begin
        result_o = {1'b0, operand_i[7:1]};
        carry_o = operand_i[0];
      end
      rotate_left_carry: begin
        result_o = {operand_i[6:0], carry_i};
        carry_o = operand_i[7];
      end
      rotate_right_carry: begin
        result_o = {carry_i, operand_i[7:1]};
        carry_o = operand_i[0];
      end
      arith_shift_right: begin
        result_o = {operand_i[7], operand_i[7:1]};
        carry_o = operand_i[0];
      end
      nibble_swap: begin
        result_o = {operand_i[3:0], operand_i[7:4]};
      end
      default: begin
        result_o = operand_i;
      end
    endcase
    zero_o = (result_o == 8'h00);
    neg_o = result_o[7];
    ovf_o = result_o[7] ^ carry_o;
  end
endmodule
